/* File: rtl/cpe_regs.v */
// Summary of operation
// - Register 0Ah holds four output driver enables in bits 3 to 0 and the beep path enable in bit 7, all reset to 0.
// - Register 0Bh holds system clock enable bit 14, playback converter enables bits 5 and 4, capture enables 3 and 2.
// - Bit 13 of register 0Bh enables the capture high-pass filter and resets to 1.
// - Bit 8 of register 0Bh runs the slow zero-cross timeout clock, which stops while the bit is 0.
// - Bit 12 of register 0Ch is the audio master enable, reset 0, and while 0 all codec registers are held in reset.
// - Bit 11 of register 0Ch enables the calendar tick and defaults to 1.
// - Bit 10 of register 0Ch enables the crystal oscillator and defaults to 1.
// - Bit 9 of register 0Ch defaults to 1 and forces charge current to zero when cleared.
// - Bits 11 to 9 of register 0Ch take a write only when the security key is open, and their defaults are mask options.
// - Bit 8 of register 0Ch resets to 0 and, when 1, drives the backup supply onto the switched backup pin.
// - Bits 3 to 0 of register 0Ch enable comparators four down to one, each reset to 0.
// - Every enable of register 0Ch, the aux converter bit 7 included, returns to default on a power state machine reset.
`timescale 1ns/1ps
`include "cpe_consts.vh"

module cpe_regs #(
  parameter ADDR_W = `CPE_ADDR_W,
  parameter DATA_W = `CPE_DATA_W,
  parameter [0:0] CALENDAR_TICK_DEFAULT = `CPE_MASK_OPT_CALENDAR_TICK,
  parameter [0:0] CRYSTAL_OSC_DEFAULT = `CPE_MASK_OPT_CRYSTAL_OSC,
  parameter [0:0] CHARGER_DEFAULT = `CPE_MASK_OPT_CHARGER,
  parameter TIMEOUT_DIV = `CPE_TIMEOUT_DIV,
  parameter TIMEOUT_CNT_W = `CPE_TIMEOUT_CNT_W
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire wr_en_i,
  input wire [ADDR_W-1:0] wr_addr_i,
  input wire [DATA_W-1:0] wr_data_i,
  input wire rd_en_i,
  input wire [ADDR_W-1:0] rd_addr_i,
  input wire key_unlocked_i,
  input wire sm_reset_i,
  output reg [DATA_W-1:0] rd_data_o,
  output reg rd_valid_o,
  output reg first_out_left_enable_o,
  output reg first_out_right_enable_o,
  output reg second_out_left_enable_o,
  output reg second_out_right_enable_o,
  output reg beep_path_enable_o,
  output reg left_capture_converter_enable_o,
  output reg right_capture_converter_enable_o,
  output reg left_playback_converter_enable_o,
  output reg right_playback_converter_enable_o,
  output reg timeout_slow_clock_enable_o,
  output reg capture_highpass_enable_o,
  output reg codec_system_clock_enable_o,
  output wire timeout_tick_o,
  output reg audio_master_enable_o,
  output reg codec_regs_reset_n_o,
  output reg calendar_tick_enable_o,
  output reg crystal_osc_enable_o,
  output reg charger_enable_o,
  output reg backup_supply_out_enable_o,
  output reg aux_converter_enable_o,
  output reg [3:0] comparator_enable_o
);

  // Mask-option defaults of the key-protected bits are parameters so a variant only overrides them.
  localparam [DATA_W-1:0] SYSTEM_BLOCK_DEFAULT = `CPE_RST_SYSTEM_BLOCK_BASE |
    ({{(DATA_W-1){1'b0}}, CALENDAR_TICK_DEFAULT} << `CPE_BIT_CALENDAR_TICK) |
    ({{(DATA_W-1){1'b0}}, CRYSTAL_OSC_DEFAULT} << `CPE_BIT_CRYSTAL_OSC) |
    ({{(DATA_W-1){1'b0}}, CHARGER_DEFAULT} << `CPE_BIT_CHARGER);

  reg [DATA_W-1:0] output_driver_enables;
  reg [DATA_W-1:0] converter_clock_enables;
  reg [DATA_W-1:0] system_block_enables;
  reg [DATA_W-1:0] next_output_driver_enables;
  reg [DATA_W-1:0] next_converter_clock_enables;
  reg [DATA_W-1:0] next_system_block_enables;
  reg [DATA_W-1:0] next_rd_data;
  reg [DATA_W-1:0] system_write_mask;
  wire codec_running;
  wire wr_output_driver;
  wire wr_converter_clock;
  wire wr_system_block;

  assign codec_running = system_block_enables[`CPE_BIT_AUDIO_MASTER];
  assign wr_output_driver = wr_en_i && (wr_addr_i == `CPE_OFS_OUTPUT_DRIVER);
  assign wr_converter_clock = wr_en_i && (wr_addr_i == `CPE_OFS_CONVERTER_CLOCK);
  assign wr_system_block = wr_en_i && (wr_addr_i == `CPE_OFS_SYSTEM_BLOCK);

  // Codec registers are held at their defaults while the master enable is clear.
  always @* begin
    next_output_driver_enables = output_driver_enables;
    next_converter_clock_enables = converter_clock_enables;
    if (!codec_running) begin
      next_output_driver_enables = `CPE_RST_OUTPUT_DRIVER;
      next_converter_clock_enables = `CPE_RST_CONVERTER_CLOCK;
    end else begin
      if (wr_output_driver) begin
        next_output_driver_enables = wr_data_i & `CPE_MASK_OUTPUT_DRIVER;
      end
      if (wr_converter_clock) begin
        next_converter_clock_enables = wr_data_i & `CPE_MASK_CONVERTER_CLOCK;
      end
    end
  end

  // Key-protected bits keep their value on a write unless the security key is open.
  // A power state machine reset wins over a write to the same register in that cycle.
  always @* begin
    system_write_mask = `CPE_MASK_SYSTEM_BLOCK;
    if (!key_unlocked_i) begin
      system_write_mask = `CPE_MASK_SYSTEM_BLOCK & ~`CPE_MASK_KEY_PROTECTED;
    end
    next_system_block_enables = system_block_enables;
    if (sm_reset_i) begin
      next_system_block_enables = SYSTEM_BLOCK_DEFAULT;
    end else if (wr_system_block) begin
      next_system_block_enables = (system_block_enables & ~system_write_mask) |
        (wr_data_i & system_write_mask);
    end
  end

  // Unmapped addresses read back as zero.
  always @* begin
    case (rd_addr_i)
      `CPE_OFS_OUTPUT_DRIVER: begin
        next_rd_data = output_driver_enables;
      end
      `CPE_OFS_CONVERTER_CLOCK: begin
        next_rd_data = converter_clock_enables;
      end
      `CPE_OFS_SYSTEM_BLOCK: begin
        next_rd_data = system_block_enables;
      end
      default: begin
        next_rd_data = {DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      output_driver_enables <= `CPE_RST_OUTPUT_DRIVER;
      converter_clock_enables <= `CPE_RST_CONVERTER_CLOCK;
      system_block_enables <= SYSTEM_BLOCK_DEFAULT;
    end else begin
      output_driver_enables <= next_output_driver_enables;
      converter_clock_enables <= next_converter_clock_enables;
      system_block_enables <= next_system_block_enables;
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Read data is taken one edge after the strobe and holds until the next read.
      rd_data_o <= {DATA_W{1'b0}};
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= next_rd_data;
      end
    end
  end

  // Enable outputs mirror the next register value so they change with the register, from flip-flops.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      first_out_left_enable_o <= 1'b0;
      first_out_right_enable_o <= 1'b0;
      second_out_left_enable_o <= 1'b0;
      second_out_right_enable_o <= 1'b0;
      beep_path_enable_o <= 1'b0;
      left_capture_converter_enable_o <= 1'b0;
      right_capture_converter_enable_o <= 1'b0;
      left_playback_converter_enable_o <= 1'b0;
      right_playback_converter_enable_o <= 1'b0;
      timeout_slow_clock_enable_o <= 1'b0;
      capture_highpass_enable_o <= 1'b1;
      codec_system_clock_enable_o <= 1'b0;
      audio_master_enable_o <= 1'b0;
      codec_regs_reset_n_o <= 1'b0;
      calendar_tick_enable_o <= CALENDAR_TICK_DEFAULT;
      crystal_osc_enable_o <= CRYSTAL_OSC_DEFAULT;
      charger_enable_o <= CHARGER_DEFAULT;
      backup_supply_out_enable_o <= 1'b0;
      aux_converter_enable_o <= 1'b0;
      comparator_enable_o <= 4'h0;
    end else begin
      first_out_left_enable_o <= next_output_driver_enables[`CPE_BIT_FIRST_OUT_LEFT];
      first_out_right_enable_o <= next_output_driver_enables[`CPE_BIT_FIRST_OUT_RIGHT];
      second_out_left_enable_o <= next_output_driver_enables[`CPE_BIT_SECOND_OUT_LEFT];
      second_out_right_enable_o <= next_output_driver_enables[`CPE_BIT_SECOND_OUT_RIGHT];
      beep_path_enable_o <= next_output_driver_enables[`CPE_BIT_BEEP_PATH];
      left_capture_converter_enable_o <= next_converter_clock_enables[`CPE_BIT_LEFT_CAPTURE];
      right_capture_converter_enable_o <= next_converter_clock_enables[`CPE_BIT_RIGHT_CAPTURE];
      left_playback_converter_enable_o <= next_converter_clock_enables[`CPE_BIT_LEFT_PLAYBACK];
      right_playback_converter_enable_o <= next_converter_clock_enables[`CPE_BIT_RIGHT_PLAYBACK];
      timeout_slow_clock_enable_o <= next_converter_clock_enables[`CPE_BIT_TIMEOUT_CLOCK];
      capture_highpass_enable_o <= next_converter_clock_enables[`CPE_BIT_CAPTURE_HIGHPASS];
      codec_system_clock_enable_o <= next_converter_clock_enables[`CPE_BIT_SYSTEM_CLOCK];
      audio_master_enable_o <= next_system_block_enables[`CPE_BIT_AUDIO_MASTER];
      codec_regs_reset_n_o <= next_system_block_enables[`CPE_BIT_AUDIO_MASTER];
      calendar_tick_enable_o <= next_system_block_enables[`CPE_BIT_CALENDAR_TICK];
      crystal_osc_enable_o <= next_system_block_enables[`CPE_BIT_CRYSTAL_OSC];
      charger_enable_o <= next_system_block_enables[`CPE_BIT_CHARGER];
      backup_supply_out_enable_o <= next_system_block_enables[`CPE_BIT_BACKUP_SUPPLY_OUT];
      aux_converter_enable_o <= next_system_block_enables[`CPE_BIT_AUX_CONVERTER];
      comparator_enable_o <=
        next_system_block_enables[`CPE_BIT_COMPARATOR_HI:`CPE_BIT_COMPARATOR_LO];
    end
  end

  // The tick counts from the registered enable, so the first pulse trails the enable by the divider length.
  cpe_timeout_clk #(
    .DIV(TIMEOUT_DIV),
    .CNT_W(TIMEOUT_CNT_W)
  ) u_timeout_clk (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(timeout_slow_clock_enable_o),
    .tick_o(timeout_tick_o)
  );

endmodule // cpe_regs

/* File: include/cpe_consts.vh */
`ifndef CPE_CONSTS_VH
`define CPE_CONSTS_VH

`define CPE_ADDR_W 8
`define CPE_DATA_W 16

`define CPE_OFS_OUTPUT_DRIVER 8'h0a
`define CPE_OFS_CONVERTER_CLOCK 8'h0b
`define CPE_OFS_SYSTEM_BLOCK 8'h0c

`define CPE_MASK_OUTPUT_DRIVER 16'h008f
`define CPE_MASK_CONVERTER_CLOCK 16'h613c
`define CPE_MASK_SYSTEM_BLOCK 16'h1f8f
`define CPE_MASK_KEY_PROTECTED 16'h0e00

`define CPE_RST_OUTPUT_DRIVER 16'h0000
`define CPE_RST_CONVERTER_CLOCK 16'h2000
`define CPE_RST_SYSTEM_BLOCK_BASE 16'h0000

`define CPE_BIT_FIRST_OUT_LEFT 0
`define CPE_BIT_FIRST_OUT_RIGHT 1
`define CPE_BIT_SECOND_OUT_LEFT 2
`define CPE_BIT_SECOND_OUT_RIGHT 3
`define CPE_BIT_BEEP_PATH 7

`define CPE_BIT_LEFT_CAPTURE 2
`define CPE_BIT_RIGHT_CAPTURE 3
`define CPE_BIT_LEFT_PLAYBACK 4
`define CPE_BIT_RIGHT_PLAYBACK 5
`define CPE_BIT_TIMEOUT_CLOCK 8
`define CPE_BIT_CAPTURE_HIGHPASS 13
`define CPE_BIT_SYSTEM_CLOCK 14

`define CPE_BIT_COMPARATOR_LO 0
`define CPE_BIT_COMPARATOR_HI 3
`define CPE_BIT_AUX_CONVERTER 7
`define CPE_BIT_BACKUP_SUPPLY_OUT 8
`define CPE_BIT_CHARGER 9
`define CPE_BIT_CRYSTAL_OSC 10
`define CPE_BIT_CALENDAR_TICK 11
`define CPE_BIT_AUDIO_MASTER 12

`define CPE_MASK_OPT_CALENDAR_TICK 1'b1
`define CPE_MASK_OPT_CRYSTAL_OSC 1'b1
`define CPE_MASK_OPT_CHARGER 1'b1

`define CPE_TIMEOUT_DIV 256
`define CPE_TIMEOUT_CNT_W 8

`endif

/* File: rtl/cpe_timeout_clk.v */
`timescale 1ns/1ps
`include "cpe_consts.vh"

// Slow tick for the zero-cross timeout; stopped and cleared whenever disabled.
module cpe_timeout_clk #(
  parameter DIV = `CPE_TIMEOUT_DIV,
  parameter CNT_W = `CPE_TIMEOUT_CNT_W
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire enable_i,
  output reg tick_o
);

  reg [CNT_W-1:0] count;
  wire at_end;

  assign at_end = (count == DIV[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
    end else if (!enable_i) begin
      count <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
    end else begin
      tick_o <= at_end;
      if (at_end) begin
        count <= {CNT_W{1'b0}};
      end else begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // cpe_timeout_clk

/* File: bench/cpe_host.sv */
`timescale 1ns/1ps
module cpe_host (
  input wire clk_i,
  input wire [15:0] rd_data_i,
  input wire rd_valid_i,
  output logic wr_en_o = 1'b0,
  output logic [7:0] wr_addr_o = 8'h00,
  output logic [15:0] wr_data_o = 16'h0000,
  output logic rd_en_o = 1'b0,
  output logic [7:0] rd_addr_o = 8'h00
);
  // Released fields are inverted so a stale word can never pass for a fresh one.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(negedge clk_i);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    rd_addr_o = ~a;
    d = rd_data_i;
    v = rd_valid_i;
  endtask
endmodule // cpe_host

/* File: bench/cpe_regs_asserts.sv */
`timescale 1ns/1ps
module cpe_regs_asserts #(parameter int TIMEOUT_DIV = 4) (
  input wire clk_i,
  input wire reset_n_i,
  input wire wr_en_i,
  input wire [7:0] wr_addr_i,
  input wire [15:0] wr_data_i,
  input wire rd_en_i,
  input wire [7:0] rd_addr_i,
  input wire key_unlocked_i,
  input wire sm_reset_i,
  input wire [15:0] rd_data_o,
  input wire rd_valid_o,
  input wire first_out_left_enable_o,
  input wire beep_path_enable_o,
  input wire capture_highpass_enable_o,
  input wire timeout_slow_clock_enable_o,
  input wire timeout_tick_o,
  input wire audio_master_enable_o,
  input wire codec_regs_reset_n_o,
  input wire calendar_tick_enable_o,
  input wire crystal_osc_enable_o,
  input wire charger_enable_o,
  input wire aux_converter_enable_o,
  input wire [3:0] comparator_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [10:0] en_run;
  // Counts consecutive sampled cycles with the slow clock enable high, saturating.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_run <= 11'h000;
    end else if (!timeout_slow_clock_enable_o) begin
      en_run <= 11'h000;
    end else if (en_run != 11'h7ff) begin
      en_run <= en_run + 11'h001;
    end
  end
  a_write_output_drv: assert property (wr_en_i && wr_addr_i == 8'h0a && audio_master_enable_o
    |=> {beep_path_enable_o, first_out_left_enable_o} == {$past(wr_data_i[7]), $past(wr_data_i[0])})
    else $error("output driver write lost");
  a_master_gate: assert property (!audio_master_enable_o
    |=> !beep_path_enable_o && !first_out_left_enable_o && capture_highpass_enable_o) else $error("codec regs not held");
  a_codec_rst_follow: assert property (codec_regs_reset_n_o == audio_master_enable_o)
    else $error("codec reset does not follow master");
  a_sm_default: assert property (sm_reset_i |=> calendar_tick_enable_o && crystal_osc_enable_o && charger_enable_o
    && !audio_master_enable_o && !aux_converter_enable_o && comparator_enable_o == 4'h0) else $error("sm reset missed");
  a_key_guard: assert property (!key_unlocked_i && !sm_reset_i
    |=> $stable({calendar_tick_enable_o, crystal_osc_enable_o, charger_enable_o})) else $error("locked bits moved");
  a_read_valid: assert property (rd_valid_o == $past(rd_en_i)) else $error("read valid timing");
  a_unmapped_zero: assert property (rd_en_i && (rd_addr_i < 8'h0a || rd_addr_i > 8'h0c)
    |=> rd_data_o == 16'h0000) else $error("unmapped read not zero");
  a_spare_zero: assert property (rd_en_i && rd_addr_i == 8'h0c
    |=> (rd_data_o & 16'he070) == 16'h0000) else $error("spare bits not zero");
  a_tick_stop: assert property (!timeout_slow_clock_enable_o |=> !timeout_tick_o)
    else $error("tick while stopped");
  a_tick_first: assert property (en_run == TIMEOUT_DIV |-> timeout_tick_o)
    else $error("first tick late");
  a_tick_early: assert property (en_run != 0 && en_run < TIMEOUT_DIV |-> !timeout_tick_o)
    else $error("tick too early");
endmodule // cpe_regs_asserts
bind cpe_regs cpe_regs_asserts #(.TIMEOUT_DIV(TIMEOUT_DIV)) i_cpe_regs_asserts (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
  .rd_addr_i(rd_addr_i), .key_unlocked_i(key_unlocked_i), .sm_reset_i(sm_reset_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .first_out_left_enable_o(first_out_left_enable_o),
  .beep_path_enable_o(beep_path_enable_o), .capture_highpass_enable_o(capture_highpass_enable_o),
  .timeout_slow_clock_enable_o(timeout_slow_clock_enable_o), .timeout_tick_o(timeout_tick_o),
  .audio_master_enable_o(audio_master_enable_o), .codec_regs_reset_n_o(codec_regs_reset_n_o),
  .calendar_tick_enable_o(calendar_tick_enable_o), .crystal_osc_enable_o(crystal_osc_enable_o),
  .charger_enable_o(charger_enable_o), .aux_converter_enable_o(aux_converter_enable_o),
  .comparator_enable_o(comparator_enable_o));

/* File: bench/cpe_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module cpe_regs_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic key_unlocked_i = 1'b0;
  logic sm_reset_i = 1'b0;
  wire wr_en, rd_en, rdv, tick, lcap, rcap, crst;
  wire [4:0] odrv, cvo;
  wire [9:0] sbo;
  wire [7:0] wa, ra;
  wire [15:0] wd, rdd;
  int err_total = 0, checks = 0, cyc = 0, n;
  logic [15:0] m0a, m0b, m0c, d;
  logic v;
  always #20 clk_i = ~clk_i;
  cpe_host i_cpe_host (.clk_i(clk_i), .rd_data_i(rdd), .rd_valid_i(rdv), .wr_en_o(wr_en), .wr_addr_o(wa),
    .wr_data_o(wd), .rd_en_o(rd_en), .rd_addr_o(ra));
  cpe_regs #(.TIMEOUT_DIV(4)) i_cpe_regs (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en), .wr_addr_i(wa),
    .wr_data_i(wd), .rd_en_i(rd_en), .rd_addr_i(ra), .key_unlocked_i(key_unlocked_i), .sm_reset_i(sm_reset_i),
    .rd_data_o(rdd), .rd_valid_o(rdv), .first_out_left_enable_o(odrv[0]), .first_out_right_enable_o(odrv[1]),
    .second_out_left_enable_o(odrv[2]), .second_out_right_enable_o(odrv[3]), .beep_path_enable_o(odrv[4]),
    .left_capture_converter_enable_o(lcap), .right_capture_converter_enable_o(rcap),
    .left_playback_converter_enable_o(cvo[0]), .right_playback_converter_enable_o(cvo[1]),
    .timeout_slow_clock_enable_o(cvo[2]), .capture_highpass_enable_o(cvo[3]), .codec_system_clock_enable_o(cvo[4]),
    .timeout_tick_o(tick), .audio_master_enable_o(sbo[9]), .codec_regs_reset_n_o(crst),
    .calendar_tick_enable_o(sbo[8]), .crystal_osc_enable_o(sbo[7]), .charger_enable_o(sbo[6]),
    .backup_supply_out_enable_o(sbo[5]), .aux_converter_enable_o(sbo[4]), .comparator_enable_o(sbo[3:0]));
  function automatic logic [15:0] expd(input logic [7:0] a);
    case (a)
      8'h0a: return m0a;
      8'h0b: return m0b;
      8'h0c: return m0c;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic wrx(input logic [7:0] a, input logic [15:0] dd);
    i_cpe_host.wr(a, dd);
    if (a == 8'h0a && m0c[12]) m0a = dd & 16'h008f;
    if (a == 8'h0b && m0c[12]) m0b = dd & 16'h613c;
    if (a == 8'h0c) m0c = (dd & 16'h118f) | ((key_unlocked_i ? dd : m0c) & 16'h0e00);
    if (!m0c[12]) begin
      m0a = 16'h0000;
      m0b = 16'h2000;
    end
  endtask
  task automatic rdall(input string s);
    for (int a = 9; a < 14; a++) begin
      i_cpe_host.rd(a[7:0], d, v);
      `CHK("rd_valid", 1'b1, v)
      `CHK("rd_data", expd(a[7:0]), d)
    end
    `CHK("drv_outs", {m0a[7], m0a[3:0]}, odrv)
    `CHK("conv_outs", {m0b[14:13], m0b[8], m0b[5:2]}, {cvo, rcap, lcap})
    `CHK("sys_outs", {m0c[12:7], m0c[3:0]}, sbo)
    $display("test %s done", s);
  endtask
  task automatic ticks(input int c, input int e);
    n = 0;
    repeat (c) begin
      @(negedge clk_i);
      n += tick;
    end
    `CHK("ticks", e, n)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    m0a = 16'h0000;
    m0b = 16'h2000;
    m0c = 16'h0e00;
    n = $urandom(32'h6b9b);
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    rdall("defaults");
    wrx(8'h0a, 16'hffff);
    wrx(8'h0b, 16'hffff);
    `CHK("codec_rst_n", 1'b0, crst)
    rdall("gated");
    wrx(8'h0c, 16'h1000);
    wrx(8'h0b, 16'h000c);
    `CHK("capture_pair", 3'b111, {lcap, rcap, crst})
    wrx(8'h0b, 16'h0100);
    ticks(40, 10);
    wrx(8'h0b, 16'h0000);
    ticks(20, 0);
    repeat (60) begin
      key_unlocked_i = $urandom_range(1);
      wrx(8'h09 + $urandom_range(4), $urandom);
    end
    rdall("random");
    key_unlocked_i = 1'b1;
    wrx(8'h0c, 16'hffff);
    wrx(8'h0a, 16'hffff);
    rdall("all_set");
    @(negedge clk_i);
    sm_reset_i = 1'b1;
    @(negedge clk_i);
    sm_reset_i = 1'b0;
    m0a = 16'h0000;
    m0b = 16'h2000;
    m0c = 16'h0e00;
    rdall("state_reset");
    close_out();
  end
endmodule // cpe_regs_tb
